// ---- inc/psv_access_regs.vh ----
`ifndef PSV_ACCESS_REGS_VH
`define PSV_ACCESS_REGS_VH
// ------------------------------------------------------------
// Register offsets (byte addresses, 32-bit words)
// ------------------------------------------------------------
`define ADDR_TABLE_PAGE    4'h0
`define ADDR_VIS_PAGE      4'h4
`define ADDR_CORE_CONTROL  4'h8
`define ADDR_STATUS        4'hc
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CORE_CONTROL_REG_VIS_BIT     2
`define TABLE_PAGE_REG_CFG_BIT     7
`define TABLE_PAGE_RST     8'h00
`define VIS_PAGE_RST       8'h00
`define CORE_CONTROL_RST   16'h0000
// ------------------------------------------------------------
// Flash geometry and timing counts
// ------------------------------------------------------------
`define ROW_WORDS          7'h40
`define ROW_BYTES          8'hc0
`define PAGE_WORDS         10'h200
`define PAGE_BYTES         11'h600
`define ROW_WORD_BITS      6
`define PAGE_WORD_BITS     9
`define VIS_EXTRA_MOVE     2'h1
`define VIS_EXTRA_OTHER    2'h2
`define VIS_EXTRA_LOOP     2'h1
`define VIS_EXTRA_LOOP_EDGE 2'h2
`endif

// ---- hdl/table_read_mux.v ----
`timescale 1ns/1ns
`include "psv_access_regs.vh"
module table_read_mux (
   input  wire [23:0] word_i,      // Program word
   input  wire        high_i,      // High-table read
   input  wire        byte_mode_i, // Byte mode
   input  wire        byte_sel_i,  // Byte select
   output reg  [15:0] data_o       // Data result
);
   always @* begin
      if (!high_i) begin
         if (!byte_mode_i)
            data_o = word_i[15:0];
         else if (byte_sel_i)
            data_o = {8'h00, word_i[15:8]};
         else
            data_o = {8'h00, word_i[7:0]};
      end else begin
         if (!byte_mode_i)
            data_o = {8'h00, word_i[23:16]};
         else if (byte_sel_i)
            data_o = 16'h0000;
         else
            data_o = {8'h00, word_i[23:16]};
      end
   end
endmodule

// ---- hdl/vis_cost_calc.v ----
`timescale 1ns/1ns
`include "psv_access_regs.vh"
module vis_cost_calc (
   input  wire       is_move_i,    // Move or double move
   input  wire       in_loop_i,    // Inside repeat loop
   input  wire       loop_edge_i,  // First/last/irq exit/re-entry
   output reg  [1:0] extra_o       // Extra cycles
);
   always @* begin
      if (in_loop_i) begin
         if (loop_edge_i)
            extra_o = `VIS_EXTRA_LOOP_EDGE;
         else
            extra_o = `VIS_EXTRA_LOOP;
      end else if (is_move_i)
         extra_o = `VIS_EXTRA_MOVE;
      else
         extra_o = `VIS_EXTRA_OTHER;
   end
endmodule

// ---- hdl/program_space_data_access.v ----
`timescale 1ns/1ns
`include "psv_access_regs.vh"
module program_space_data_access (
   input  wire        clk_i,          // System clock
   input  wire        rst_i,          // Sync reset, active high
   // Wishbone slave
   input  wire        wb_cyc_i,       // Cycle
   input  wire        wb_stb_i,       // Strobe
   input  wire        wb_we_i,        // Write enable
   input  wire [3:0]  wb_adr_i,       // Byte address
   input  wire [3:0]  wb_sel_i,       // Byte lanes
   input  wire [31:0] wb_dat_i,       // Write data
   output reg  [31:0] wb_dat_o,       // Read data
   output reg         wb_ack_o,       // Acknowledge
   // Core request
   input  wire        req_i,          // Access request pulse
   input  wire [1:0]  op_i,           // 0 data,1 tbl rd,2 tbl wt
   input  wire        high_i,         // High-table op
   input  wire        byte_mode_i,    // Byte mode
   input  wire [15:0] ea_i,           // Effective address
   input  wire [15:0] wdata_i,        // Table write data
   input  wire        is_move_i,      // Move or double move
   input  wire        in_loop_i,      // Inside repeat loop
   input  wire        loop_edge_i,    // Loop edge iteration
   input  wire        prog_row_i,     // Row program mode
   output reg         done_o,         // Result valid pulse
   output reg  [15:0] rdata_o,        // Read data to core
   output reg  [1:0]  extra_o,        // Extra cycles charged
   output reg         redirect_o,     // Data access went to program space
   output wire        busy_o,         // Block busy
   // Program memory
   output reg  [23:0] pm_addr_o,      // Program address
   output reg         pm_rd_o,        // Read strobe
   input  wire [23:0] pm_rdata_i,     // Read word
   output reg         pm_wr_o,        // Write strobe
   output reg  [23:0] pm_wdata_o,     // Write word
   output reg  [23:0] pm_wmask_o,     // Write bit mask
   output reg  [9:0]  erase_base_o,   // Word offset of erase page
   output reg  [5:0]  row_index_o     // Word index within row
);
   // ---------------------------------------------------------
   // Constants
   // ---------------------------------------------------------
   localparam OP_DATA = 2'h0;
   localparam OP_TRD  = 2'h1;
   localparam OP_TWT  = 2'h2;
   localparam ST_IDLE  = 2'h0;
   localparam ST_FETCH = 2'h1;
   localparam ST_EXTRA = 2'h2;
   localparam ST_DONE  = 2'h3;
   // ---------------------------------------------------------
   // Registers
   // ---------------------------------------------------------
   reg  [7:0]  table_page_reg;
   reg  [7:0]  visibility_page_reg;
   reg  [15:0] core_control_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg         table_active_reg;
   reg         high_reg;
   reg         byte_mode_reg;
   reg         byte_sel_reg;
   reg         vis_reg;
   reg  [1:0]  cost_reg;
   reg  [1:0]  wait_reg;
   wire        visibility_enable;
   wire [15:0] mux_data;
   wire [1:0]  cost;
   wire        wb_req;
   wire        vis_hit;
   assign visibility_enable = core_control_reg[`CORE_CONTROL_REG_VIS_BIT];
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Table op in flight masks the window
   assign vis_hit = ea_i[15] & visibility_enable
                    & ~table_active_reg;
   assign busy_o = (state_reg != ST_IDLE);
   function [31:0] reg_read;
      input [3:0] adr;
      begin
         case (adr)
            `ADDR_TABLE_PAGE:   reg_read = {24'h000000, table_page_reg};
            `ADDR_VIS_PAGE:     reg_read = {24'h000000, visibility_page_reg};
            `ADDR_CORE_CONTROL: reg_read = {16'h0000, core_control_reg};
            `ADDR_STATUS:
               reg_read = {28'h0000000, vis_reg, table_active_reg,
                           state_reg};
            default:            reg_read = 32'h00000000;
         endcase
      end
   endfunction
   // ---------------------------------------------------------
   // Wishbone slave, one wait-free ack
   // ---------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o            <= 1'b0;
         wb_dat_o            <= 32'h00000000;
         table_page_reg      <= `TABLE_PAGE_RST;
         visibility_page_reg <= `VIS_PAGE_RST;
         core_control_reg    <= `CORE_CONTROL_RST;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= reg_read(wb_adr_i);
            if (wb_we_i) begin
               case (wb_adr_i)
                  `ADDR_TABLE_PAGE:
                     if (wb_sel_i[0])
                        table_page_reg <= wb_dat_i[7:0];
                  `ADDR_VIS_PAGE:
                     if (wb_sel_i[0])
                        visibility_page_reg <= wb_dat_i[7:0];
                  `ADDR_CORE_CONTROL: begin
                     if (wb_sel_i[0])
                        core_control_reg[7:0] <= wb_dat_i[7:0];
                     if (wb_sel_i[1])
                        core_control_reg[15:8] <= wb_dat_i[15:8];
                  end
                  default: ;
               endcase
            end
         end
      end
   end
   // ---------------------------------------------------------
   // Access sequencer
   // ---------------------------------------------------------
   table_read_mux u_mux (
      .word_i      (pm_rdata_i),
      .high_i      (high_reg),
      .byte_mode_i (byte_mode_reg),
      .byte_sel_i  (byte_sel_reg),
      .data_o      (mux_data)
   );
   vis_cost_calc u_cost (
      .is_move_i   (is_move_i),
      .in_loop_i   (in_loop_i),
      .loop_edge_i (loop_edge_i),
      .extra_o     (cost)
   );
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:  if (req_i) state_next = ST_FETCH;
         ST_FETCH: state_next = (wait_reg != 2'h0) ? ST_EXTRA : ST_DONE;
         // One extra state per charged cycle, counted down in EXTRA only
         ST_EXTRA: if (wait_reg <= 2'h1) state_next = ST_DONE;
         ST_DONE:  state_next = ST_IDLE;
         default:  state_next = ST_IDLE;
      endcase
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg        <= ST_IDLE;
         table_active_reg <= 1'b0;
         high_reg         <= 1'b0;
         byte_mode_reg    <= 1'b0;
         byte_sel_reg     <= 1'b0;
         vis_reg          <= 1'b0;
         cost_reg         <= 2'h0;
         wait_reg         <= 2'h0;
         done_o           <= 1'b0;
         rdata_o          <= 16'h0000;
         extra_o          <= 2'h0;
         redirect_o       <= 1'b0;
         pm_addr_o        <= 24'h000000;
         pm_rd_o          <= 1'b0;
         pm_wr_o          <= 1'b0;
         pm_wdata_o       <= 24'h000000;
         pm_wmask_o       <= 24'h000000;
         erase_base_o     <= 10'h000;
         row_index_o      <= 6'h00;
      end else begin
         state_reg <= state_next;
         done_o    <= 1'b0;
         pm_rd_o   <= 1'b0;
         pm_wr_o   <= 1'b0;
         case (state_reg)
            ST_IDLE: if (req_i) begin
               high_reg      <= high_i;
               byte_mode_reg <= byte_mode_i;
               byte_sel_reg  <= ea_i[0];
               if (op_i == OP_DATA) begin
                  vis_reg <= vis_hit;
                  // Page bit 0 replaces address bit 15
                  pm_addr_o <= {1'b0, visibility_page_reg,
                                ea_i[14:0]};
                  pm_rd_o   <= vis_hit;
                  cost_reg  <= vis_hit ? cost : 2'h0;
                  wait_reg  <= vis_hit ? cost : 2'h0;
               end else begin
                  vis_reg          <= 1'b0;
                  table_active_reg <= 1'b1;
                  // Word address steps by two per program word
                  pm_addr_o <= {table_page_reg, ea_i[15:1],
                                1'b0};
                  pm_rd_o   <= (op_i == OP_TRD);
                  pm_wr_o   <= (op_i == OP_TWT);
                  cost_reg  <= 2'h0;
                  wait_reg  <= 2'h0;
                  if (high_i) begin
                     pm_wdata_o <= {wdata_i[7:0], 16'h0000};
                     pm_wmask_o <= (byte_mode_i & ea_i[0]) ?
                                   24'h000000 : 24'hff0000;
                  end else if (byte_mode_i) begin
                     pm_wdata_o <= {8'h00, wdata_i[7:0], wdata_i[7:0]};
                     pm_wmask_o <= ea_i[0] ? 24'h00ff00 : 24'h0000ff;
                  end else begin
                     pm_wdata_o <= {8'h00, wdata_i};
                     pm_wmask_o <= 24'h00ffff;
                  end
                  // Row and page placement for self-programming
                  row_index_o  <= prog_row_i ?
                                  ea_i[`ROW_WORD_BITS:1] : 6'h00;
                  erase_base_o <= {ea_i[15:`PAGE_WORD_BITS+1],
                                   4'h0} & 10'h3f0;
               end
            end
            ST_FETCH: ;
            ST_EXTRA: if (wait_reg != 2'h0)
               wait_reg <= wait_reg - 2'h1;
            ST_DONE: begin
               done_o           <= 1'b1;
               extra_o          <= cost_reg;
               redirect_o       <= vis_reg;
               table_active_reg <= 1'b0;
               if (vis_reg)
                  rdata_o <= pm_rdata_i[15:0];
               else if (table_active_reg)
                  rdata_o <= mux_data;
               else
                  rdata_o <= 16'h0000;
            end
            default: ;
         endcase
      end
   end
endmodule

// ---- bench/psv_access_asserts.sv ----
`timescale 1ns/1ns
module psv_access_asserts (
   input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire [3:0]  wb_adr_i, wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire        req_i, high_i, byte_mode_i, is_move_i, in_loop_i,
   input wire        loop_edge_i, done_o, redirect_o, busy_o, pm_rd_o,
   input wire [1:0]  op_i, extra_o,
   input wire [15:0] ea_i, rdata_o,
   input wire [23:0] pm_addr_o, pm_rdata_i
);
   // ----------------------------------------------------------
   // Shadow of page registers and of the request in flight
   // ----------------------------------------------------------
   reg  [7:0]  tp_q, vp_q;
   reg         vis_q, hi_q, bm_q, mv_q, lp_q, ed_q, hit_q;
   reg  [1:0]  op_q;
   reg  [15:0] ea_q;
   reg  [2:0]  cnt_q;
   wire        take = req_i && !busy_o;
   wire        wbw = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire [7:0]  lb = ea_q[0] ? pm_rdata_i[15:8] : pm_rdata_i[7:0];
   wire [15:0] trd = hi_q ? ((bm_q && ea_q[0]) ? 16'h0000
                     : {8'h00, pm_rdata_i[23:16]})
                     : (bm_q ? {8'h00, lb} : pm_rdata_i[15:0]);
   wire [1:0]  ex = lp_q ? (ed_q ? 2'h2 : 2'h1) : (mv_q ? 2'h1 : 2'h2);
   always @(posedge clk_i) begin
      if (rst_i) begin
         {tp_q, vp_q, vis_q, cnt_q} <= {8'h00, 8'h00, 1'b0, 3'h0};
      end else begin
         if (wbw && wb_adr_i == 4'h0 && wb_sel_i[0]) tp_q <= wb_dat_i[7:0];
         if (wbw && wb_adr_i == 4'h4 && wb_sel_i[0]) vp_q <= wb_dat_i[7:0];
         if (wbw && wb_adr_i == 4'h8 && wb_sel_i[0]) vis_q <= wb_dat_i[2];
         // Saturate so an idle block never wraps into a false match
         cnt_q <= take ? 3'h1 : (cnt_q == 3'h7 ? cnt_q : cnt_q + 3'h1);
      end
      if (take) begin
         {op_q, hi_q, bm_q, ea_q} <= {op_i, high_i, byte_mode_i, ea_i};
         {mv_q, lp_q, ed_q} <= {is_move_i, in_loop_i, loop_edge_i};
         hit_q <= op_i == 2'h0 && ea_i[15] && vis_q;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_tbl_take; take && op_i == 2'h1; endsequence
   sequence s_win_take; take && op_i == 2'h0 && ea_i[15] && vis_q; endsequence
   sequence s_tbl_addr; pm_rd_o && pm_addr_o == {tp_q, ea_q[15:1], 1'b0};
   endsequence
   AST_TBL_ADDR: assert property (s_tbl_take |=> s_tbl_addr)
      else $error("table address wrong");
   AST_WIN_ADDR: assert property (s_win_take |=> pm_rd_o &&
      pm_addr_o == {1'b0, vp_q, ea_q[14:0]}) else $error("window address");
   AST_NO_WIN: assert property (take && op_i == 2'h0 &&
      !(ea_i[15] && vis_q) |=> !pm_rd_o[*2]) else $error("stray fetch");
   AST_TBL_DATA: assert property (done_o && op_q == 2'h1 |->
      rdata_o == trd && extra_o == 2'h0 && !redirect_o)
      else $error("table read data wrong");
   AST_WIN_DATA: assert property (done_o && hit_q |-> redirect_o &&
      rdata_o == pm_rdata_i[15:0] && extra_o == ex)
      else $error("window data or cost wrong");
   AST_DONE_TIME: assert property (done_o |->
      cnt_q == 3'h3 + {1'b0, extra_o}) else $error("done timing wrong");
   AST_DONE_BOUND: assert property (take |-> ##[3:5] done_o)
      else $error("done missing");
   AST_DONE_PULSE: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("ack late");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
endmodule
bind program_space_data_access psv_access_asserts psv_access_asserts_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .req_i, .high_i, .byte_mode_i, .is_move_i,
   .in_loop_i, .loop_edge_i, .done_o, .redirect_o, .busy_o, .pm_rd_o, .op_i,
   .extra_o, .ea_i, .rdata_o, .pm_addr_o, .pm_rdata_i);

// ---- bench/pm_model.sv ----
`timescale 1ns/1ns
module pm_model (
   input  wire        clk_i,   // System clock
   input  wire        rd_i,    // Read strobe
   input  wire [23:0] addr_i,  // Word address
   input  wire        done_i,  // Core transfer done
   output reg  [23:0] rdata_o  // Read word
);
   // User-space words carry an all-ones or all-zeros top byte
   function automatic [23:0] word_at(input [23:0] a);
      word_at = {a[23] ? a[7:0] ^ 8'h96 : {8{a[3]}},
                 a[15:0] ^ {a[23:16], 8'h5a}};
   endfunction
   initial rdata_o = 24'h000000;
   // Held only until done, then scrambled so stale data cannot pass
   always @(posedge clk_i) begin
      if (rd_i) begin
         rdata_o <= word_at(addr_i);
      end else if (done_i) begin
         rdata_o <= ~rdata_o;
      end
   end
endmodule

// ---- bench/program_space_data_access_test.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module program_space_data_access_test;
   reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_i, high_i;
   reg         byte_mode_i, is_move_i, in_loop_i, loop_edge_i, vis, hit;
   reg  [3:0]  wb_adr_i, wb_sel_i;
   reg  [31:0] wb_dat_i, rd;
   reg  [1:0]  op_i;
   reg  [15:0] ea_i, e;
   reg  [7:0]  tp, vp;
   reg  [23:0] a, w;
   reg  [18:0] x;
   reg  [18:0] exp_q[$];
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, done_o, redirect_o, busy_o, pm_rd_o;
   wire [15:0] rdata_o;
   wire [1:0]  extra_o;
   wire [23:0] pm_addr_o, pm_rdata_i;
   integer     err_count = 0, checked = 0, seed = 27699, i;
   program_space_data_access program_space_data_access_inst (.clk_i, .rst_i,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .req_i, .op_i, .high_i, .byte_mode_i, .ea_i,
      .wdata_i(16'h0000), .is_move_i, .in_loop_i, .loop_edge_i,
      .prog_row_i(1'b0), .done_o, .rdata_o, .extra_o, .redirect_o, .busy_o,
      .pm_addr_o, .pm_rd_o, .pm_rdata_i, .pm_wr_o(), .pm_wdata_o(),
      .pm_wmask_o(), .erase_base_o(), .row_index_o());
   pm_model pm_model_inst (.clk_i, .rd_i(pm_rd_o), .addr_i(pm_addr_o),
      .done_i(done_o), .rdata_o(pm_rdata_i));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task wb(input we, input [3:0] adr, input [31:0] dat, input [3:0] sel);
      begin
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, we, adr};
         {wb_dat_i, wb_sel_i} <= {dat, sel};
         @(posedge clk_i iff wb_ack_o);
         rd = wb_dat_o;
         {wb_cyc_i, wb_stb_i} <= 2'b00;
         @(posedge clk_i);
      end
   endtask
   // f: high, byte mode, move, in loop, loop edge
   task core(input [1:0] op, input [4:0] f, input [15:0] ea);
      begin
         {high_i, byte_mode_i, is_move_i, in_loop_i, loop_edge_i} <= f;
         {req_i, op_i, ea_i} <= {1'b1, op, ea};
         hit = op == 2'h0 && ea[15] && vis;
         a = op[0] ? {tp, ea[15:1], 1'b0} : {1'b0, vp, ea[14:0]};
         w = pm_model_inst.word_at(a);
         e = !op[0] ? (hit ? w[15:0] : 16'h0000)
           : f[4] ? ((f[3] && ea[0]) ? 16'h0000 : {8'h00, w[23:16]})
           : f[3] ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
         exp_q.push_back({hit, !hit ? 2'h0 : f[1] ? (f[0] ? 2'h2 : 2'h1)
                          : (f[2] ? 2'h1 : 2'h2), e});
         @(posedge clk_i);
         req_i <= 1'b0;
         @(posedge clk_i iff done_o);
         @(posedge clk_i);
      end
   endtask
   always @(posedge clk_i) begin
      if (done_o === 1'b1) begin
         x = exp_q.pop_front();
         `CHK(rdata_o, x[15:0])
         `CHK(extra_o, x[17:16])
         `CHK(redirect_o, x[18])
      end
   end
   task finish_test;
      begin
         $display("Comparisons %0d, mismatches %0d", checked, err_count);
         if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_i, vis} = 6'b100000;
      {high_i, byte_mode_i, is_move_i, in_loop_i, loop_edge_i} = 5'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i, op_i, ea_i} = 58'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i++) begin
         wb(1'b0, {i[1:0], 2'b00}, 32'h0, 4'hf);
         `CHK(rd, 32'h00000000)
      end
      for (i = 0; i < 128; i++) begin
         if (i % 32 == 0) begin
            {tp, vp, vis} = {$random(seed), !i[5]};
            wb(1'b1, 4'h0, {24'h0, tp}, 4'h1);
            wb(1'b1, 4'h4, {24'h0, vp}, 4'h1);
            wb(1'b1, 4'h8, {29'h0, vis, 2'h0}, 4'h3);
            wb(1'b0, 4'h0, 32'h0, 4'hf);
            `CHK(rd, {24'h0, tp})
            wb(1'b0, 4'h8, 32'h0, 4'hf);
            `CHK(rd, {29'h0, vis, 2'h0})
         end
         core({1'b0, i[0]}, $random(seed), $random(seed));
      end
      finish_test;
   end
   initial begin
      #40000;
      err_count++;
      finish_test;
   end
endmodule
